// File: core/pin_router_consts.svh
// Register offsets, field positions and reset values of the interrupt pin router.
`ifndef PIN_ROUTER_CONSTS_SVH
`define PIN_ROUTER_CONSTS_SVH

// Register byte addresses on the register bus.
`define ADDR_P1_DATA 8'h00
`define ADDR_P1_FUNC 8'h04
`define ADDR_P2_DATA 8'h08
`define ADDR_P2_FUNC 8'h0C
`define ADDR_CTRL_FOUR 8'h10
`define ADDR_CTRL_FIVE 8'h14
`define ADDR_IF_CFG 8'h18
`define ADDR_FUNC_EN 8'h1C
`define ADDR_KNOCK_CFG0 8'h20
`define ADDR_SUMMARY 8'h24
`define ADDR_BASIC_SRC 8'h28

// Reset value of every routing and control register.
`define ROUTE_RESET 8'h00

// Data and queue routing fields, both pins; the busy bit is pin 2 only.
`define RT_BATCH 6
`define RT_FULL 5
`define RT_OVERRUN 4
`define RT_THRESH 3
`define RT_GYRO 1
`define RT_ACCEL 0
`define RT_P2_BUSY 7

// Function routing fields, both pins.
`define FN_ACT 7
`define FN_STAP 6
`define FN_WU 5
`define FN_FF 4
`define FN_DTAP 3
`define FN_ORIENT 2
`define FN_EMB 1
`define FN_LAST 0

// Control and configuration bits.
`define C4_TEMP 0
`define C4_MERGE 1
`define C5_I3C_PIN 0
`define IF_ACTIVE_LOW 0
`define IF_OPEN_DRAIN 1
`define FE_BASIC 0
`define FE_NO_CLEAR 1
`define FE_HG 2
`define KC_LATCH 0

// Basic event index: free-fall, wake-up, single, double, orientation, activity.
`define EV_FF 0
`define EV_WU 1
`define EV_STAP 2
`define EV_DTAP 3
`define EV_ORIENT 4
`define EV_ACT 5
`define EV_COUNT 6

// Summary register bit positions above the six basic events.
`define SUM_HG 6
`define SUM_EMB 7
`define SUM_HUB 8

`endif

// File: core/pin_router_pkg.sv
// Types of the interrupt pin router.
package pin_router_pkg;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_type;

   typedef struct packed {
      logic [7:0] p1_data;
      logic [7:0] p1_func;
      logic [7:0] p2_data;
      logic [7:0] p2_func;
      logic [1:0] ctrl_four;
      logic ctrl_five;
      logic [1:0] if_cfg;
      logic [2:0] func_en;
      logic knock_cfg;
      logic [5:0] latched;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      axi_resp_type bresp;
      logic arready;
      logic rvalid;
      axi_resp_type rresp;
      logic [31:0] rdata;
      logic pin1_level;
      logic pin1_drive_n;
      logic pin2_level;
      logic pin2_drive_n;
   } router_state_type;

endpackage

// File: core/imu_interrupt_pin_router.sv
// Interrupt routing and pin output logic with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "pin_router_consts.svh"

module imu_interrupt_pin_router
   import pin_router_pkg::*;
(
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Register bus write channels.
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // Register bus read channels.
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Basic function conditions, as levels.
   input wire logic [5:0] basic_cond_in,
   // High-g detector levels and sensor state.
   input wire logic hg_wakeup_in,
   input wire logic hg_shock_in,
   input wire logic hg_active_in,
   // Queue flags and data-ready levels.
   input wire logic queue_batch_in,
   input wire logic queue_full_in,
   input wire logic queue_overrun_in,
   input wire logic queue_threshold_in,
   input wire logic gyro_ready_in,
   input wire logic accel_ready_in,
   input wire logic temp_ready_in,
   // Embedded, hub and timestamp levels.
   input wire logic embedded_event_in,
   input wire logic embedded_running_in,
   input wire logic hub_done_in,
   input wire logic time_overflow_in,
   // Serial interface mode.
   input wire logic i3c_mode_in,
   // Interrupt pins, enable low while the pin is driven.
   output logic event_pin_one_out,
   output logic event_pin_one_oe_n_out,
   output logic event_pin_two_out,
   output logic event_pin_two_oe_n_out
);

   router_state_type st_reg;
   router_state_type st_next;

   logic [5:0] basic_gated;
   logic [5:0] basic_route1;
   logic [5:0] basic_route2;
   logic [5:0] basic_eff;
   logic hg_event;
   logic [8:0] summary;
   logic p1_any;
   logic p2_any;
   logic pins_on;
   logic ar_hs;
   logic aw_hs;
   logic w_hs;
   logic wr_go;
   logic clr_latch;
   logic [7:0] rd_addr;

   // Route bit of each basic event in a function routing register.
   localparam int FN_POS [0:5] = '{`FN_FF, `FN_WU, `FN_STAP, `FN_DTAP, `FN_ORIENT, `FN_ACT};

   // Event qualification, routing per event and the pin ORs.
   always_comb begin
      basic_gated = basic_cond_in & {6{st_reg.func_en[`FE_BASIC]}};
      for (int k = 0; k < `EV_COUNT; k++) begin
         basic_route1[k] = st_reg.p1_func[FN_POS[k]];
         basic_route2[k] = st_reg.p2_func[FN_POS[k]];
         // Latched view only when latching is on and the event is routed.
         if (st_reg.knock_cfg && (basic_route1[k] || basic_route2[k])) begin
            basic_eff[k] = st_reg.latched[k];
         end else begin
            basic_eff[k] = basic_gated[k];
         end
      end
      hg_event = (hg_wakeup_in | hg_shock_in) & st_reg.func_en[`FE_HG] & hg_active_in;
      summary = {hub_done_in, embedded_event_in, hg_event, basic_eff};
      // Each pin is the plain OR of its routed sources.
      p1_any = |(basic_eff & basic_route1)
         | (st_reg.p1_func[`FN_EMB] & embedded_event_in)
         | (st_reg.p1_func[`FN_LAST] & hub_done_in)
         | (st_reg.p1_data[`RT_BATCH] & queue_batch_in)
         | (st_reg.p1_data[`RT_FULL] & queue_full_in)
         | (st_reg.p1_data[`RT_OVERRUN] & queue_overrun_in)
         | (st_reg.p1_data[`RT_THRESH] & queue_threshold_in)
         | (st_reg.p1_data[`RT_GYRO] & gyro_ready_in)
         | (st_reg.p1_data[`RT_ACCEL] & accel_ready_in);
      p2_any = |(basic_eff & basic_route2)
         | (st_reg.p2_func[`FN_EMB] & embedded_event_in)
         | (st_reg.p2_func[`FN_LAST] & time_overflow_in)
         | (st_reg.p2_data[`RT_BATCH] & queue_batch_in)
         | (st_reg.p2_data[`RT_FULL] & queue_full_in)
         | (st_reg.p2_data[`RT_OVERRUN] & queue_overrun_in)
         | (st_reg.p2_data[`RT_THRESH] & queue_threshold_in)
         | (st_reg.p2_data[`RT_GYRO] & gyro_ready_in)
         | (st_reg.p2_data[`RT_ACCEL] & accel_ready_in)
         | (st_reg.ctrl_four[`C4_TEMP] & temp_ready_in);
      // Movable pin 2 sources also appear on pin 1 when merged.
      if (st_reg.ctrl_four[`C4_MERGE]) begin
         p1_any = p1_any
            | (st_reg.p2_data[`RT_P2_BUSY] & ~embedded_running_in)
            | (st_reg.p2_func[`FN_LAST] & time_overflow_in)
            | (st_reg.ctrl_four[`C4_TEMP] & temp_ready_in);
      end
      // The busy indication takes pin 2 over entirely.
      if (st_reg.p2_data[`RT_P2_BUSY]) begin
         p2_any = ~embedded_running_in;
      end
      pins_on = ~i3c_mode_in | st_reg.ctrl_five;
   end

   // Bus handshakes and the register decode of a read address.
   assign aw_hs = s_axi_awvalid_in & st_reg.awready;
   assign w_hs = s_axi_wvalid_in & st_reg.wready;
   assign ar_hs = s_axi_arvalid_in & st_reg.arready;
   assign wr_go = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
   assign rd_addr = s_axi_araddr_in;
   assign clr_latch = ar_hs & ((rd_addr == `ADDR_BASIC_SRC)
      | ((rd_addr == `ADDR_SUMMARY) & ~st_reg.func_en[`FE_NO_CLEAR]));

   // Next state: register writes, reads, latches and pin levels.
   always_comb begin
      st_next = st_reg;
      // Write address and data are caught in either order.
      if (aw_hs) begin
         st_next.aw_got = 1'b1;
         st_next.aw_addr = s_axi_awaddr_in;
      end
      if (w_hs) begin
         st_next.w_got = 1'b1;
         st_next.w_data = s_axi_wdata_in[7:0];
         st_next.w_lane0 = s_axi_wstrb_in[0];
      end
      if (wr_go) begin
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         if (st_reg.w_lane0) begin
            case (st_reg.aw_addr)
               `ADDR_P1_DATA: st_next.p1_data = st_reg.w_data & 8'h7B;
               `ADDR_P1_FUNC: st_next.p1_func = st_reg.w_data;
               `ADDR_P2_DATA: st_next.p2_data = st_reg.w_data & 8'hFB;
               `ADDR_P2_FUNC: st_next.p2_func = st_reg.w_data;
               `ADDR_CTRL_FOUR: st_next.ctrl_four = st_reg.w_data[1:0];
               `ADDR_CTRL_FIVE: st_next.ctrl_five = st_reg.w_data[0];
               `ADDR_IF_CFG: st_next.if_cfg = st_reg.w_data[1:0];
               `ADDR_FUNC_EN: st_next.func_en = st_reg.w_data[2:0];
               `ADDR_KNOCK_CFG0: st_next.knock_cfg = st_reg.w_data[0];
               default: st_next.bvalid = 1'b1;
            endcase
         end
         case (st_reg.aw_addr)
            `ADDR_P1_DATA, `ADDR_P1_FUNC, `ADDR_P2_DATA, `ADDR_P2_FUNC,
            `ADDR_CTRL_FOUR, `ADDR_CTRL_FIVE, `ADDR_IF_CFG, `ADDR_FUNC_EN,
            `ADDR_KNOCK_CFG0, `ADDR_SUMMARY, `ADDR_BASIC_SRC: st_next.bresp = RESP_OKAY;
            default: st_next.bresp = RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && s_axi_bready_in) begin
         st_next.bvalid = 1'b0;
      end
      // A read answers one cycle after its address is taken.
      if (ar_hs) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (rd_addr)
            `ADDR_P1_DATA: st_next.rdata = {24'h000000, st_reg.p1_data};
            `ADDR_P1_FUNC: st_next.rdata = {24'h000000, st_reg.p1_func};
            `ADDR_P2_DATA: st_next.rdata = {24'h000000, st_reg.p2_data};
            `ADDR_P2_FUNC: st_next.rdata = {24'h000000, st_reg.p2_func};
            `ADDR_CTRL_FOUR: st_next.rdata = {30'h00000000, st_reg.ctrl_four};
            `ADDR_CTRL_FIVE: st_next.rdata = {31'h00000000, st_reg.ctrl_five};
            `ADDR_IF_CFG: st_next.rdata = {30'h00000000, st_reg.if_cfg};
            `ADDR_FUNC_EN: st_next.rdata = {29'h00000000, st_reg.func_en};
            `ADDR_KNOCK_CFG0: st_next.rdata = {31'h00000000, st_reg.knock_cfg};
            `ADDR_SUMMARY: st_next.rdata = {23'h000000, summary};
            `ADDR_BASIC_SRC: st_next.rdata = {26'h0000000, basic_eff};
            default: begin
               st_next.rdata = 32'h00000000;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end else if (st_reg.rvalid && s_axi_rready_in) begin
         st_next.rvalid = 1'b0;
      end
      st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
      st_next.wready = ~st_next.w_got & ~st_next.bvalid;
      st_next.arready = ~st_next.rvalid;
      // Latch: a new event wins over a clearing read; unrouting drops it.
      for (int k = 0; k < `EV_COUNT; k++) begin
         st_next.latched[k] = st_reg.knock_cfg & (basic_route1[k] | basic_route2[k])
            & (basic_gated[k] | (st_reg.latched[k] & ~clr_latch));
      end
      // OR first, then gate, then invert for the pin sense.
      st_next.pin1_level = (p1_any & pins_on) ^ st_reg.if_cfg[`IF_ACTIVE_LOW];
      st_next.pin2_level = (p2_any & pins_on) ^ st_reg.if_cfg[`IF_ACTIVE_LOW];
      st_next.pin1_drive_n = st_reg.if_cfg[`IF_OPEN_DRAIN] & ~(p1_any & pins_on);
      st_next.pin2_drive_n = st_reg.if_cfg[`IF_OPEN_DRAIN] & ~(p2_any & pins_on);
   end

   // State register with synchronous reset; every routing bit clears.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign s_axi_awready_out = st_reg.awready;
   assign s_axi_wready_out = st_reg.wready;
   assign s_axi_bvalid_out = st_reg.bvalid;
   assign s_axi_bresp_out = st_reg.bresp;
   assign s_axi_arready_out = st_reg.arready;
   assign s_axi_rvalid_out = st_reg.rvalid;
   assign s_axi_rresp_out = st_reg.rresp;
   assign s_axi_rdata_out = st_reg.rdata;
   assign event_pin_one_out = st_reg.pin1_level;
   assign event_pin_one_oe_n_out = st_reg.pin1_drive_n;
   assign event_pin_two_out = st_reg.pin2_level;
   assign event_pin_two_oe_n_out = st_reg.pin2_drive_n;

   // Checks on the pin, latch and bus behaviour.
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   // Accelerometer ready routed to pin 1 with the pins live.
   sequence accel_routed_s;
      st_reg.p1_data[`RT_ACCEL] && accel_ready_in && pins_on;
   endsequence

   // Both write halves held and no response outstanding.
   sequence write_pair_s;
      st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
   endsequence

   // Pins live and active high, so an asserted pin reads 1.
   sequence high_live_s;
      pins_on && !st_reg.if_cfg[`IF_ACTIVE_LOW];
   endsequence

   // Free-fall latched and routed to pin 1, with no write changing the setup.
   sequence ff_held_s;
      st_reg.latched[`EV_FF] && st_reg.knock_cfg && st_reg.p1_func[`FN_FF] && !wr_go;
   endsequence

   // A routed accelerometer ready drives pin 1 active.
   route_or_a: assert property (accel_routed_s
      |=> event_pin_one_out != $past(st_reg.if_cfg[`IF_ACTIVE_LOW]))
      else $error("routed accel ready did not assert pin one");
   // Pin 2 rests inactive while the pins are off.
   idle_level_a: assert property (!pins_on
      |=> event_pin_two_out == $past(st_reg.if_cfg[`IF_ACTIVE_LOW]))
      else $error("pin two not idle while pins disabled");
   // Pin 1 rests inactive while the pins are off.
   idle_one_a: assert property (!pins_on
      |=> event_pin_one_out == $past(st_reg.if_cfg[`IF_ACTIVE_LOW]))
      else $error("pin one not idle while pins disabled");
   // Push-pull drives both pins at all times.
   push_pull_a: assert property (!st_reg.if_cfg[`IF_OPEN_DRAIN]
      |=> !event_pin_one_oe_n_out && !event_pin_two_oe_n_out)
      else $error("push-pull pin released");
   // Open drain lets go of an inactive pin.
   drain_release_a: assert property (st_reg.if_cfg[`IF_OPEN_DRAIN]
      && !(p1_any && pins_on) |=> event_pin_one_oe_n_out)
      else $error("open-drain pin one driven while inactive");
   // Busy routing pulls pin 2 low while an embedded function runs.
   busy_pin_a: assert property (st_reg.p2_data[`RT_P2_BUSY] && embedded_running_in
      && !st_reg.if_cfg[`IF_ACTIVE_LOW] |=> !event_pin_two_out)
      else $error("pin two high while embedded busy");
   // Busy routing holds pin 2 high while nothing embedded runs.
   busy_idle_a: assert property (high_live_s
      ##0 (st_reg.p2_data[`RT_P2_BUSY] && !embedded_running_in) |=> event_pin_two_out)
      else $error("pin two low while embedded idle");
   // Merged temperature ready shows on pin 1.
   merge_temp_a: assert property (high_live_s
      ##0 (st_reg.ctrl_four == 2'h3 && temp_ready_in) |=> event_pin_one_out)
      else $error("merged temperature ready missing on pin one");
   // With basic functions off no latch can be set.
   basic_off_a: assert property (!st_reg.func_en[`FE_BASIC]
      && st_reg.latched == 6'h00 |=> st_reg.latched == 6'h00)
      else $error("latch set with basic functions disabled");
   // A routed latch holds until a clearing read.
   latch_hold_a: assert property (ff_held_s ##0 !clr_latch
      |=> st_reg.latched[`EV_FF])
      else $error("free-fall latch dropped without a read");
   // With no-clear set a summary read leaves the latch alone.
   summary_keep_a: assert property (ff_held_s
      ##0 (ar_hs && rd_addr == `ADDR_SUMMARY && st_reg.func_en[`FE_NO_CLEAR])
      |=> st_reg.latched[`EV_FF])
      else $error("summary read cleared a latch under no-clear");
   // A basic source read clears a latch whose event has ended.
   clear_read_a: assert property (ar_hs && rd_addr == `ADDR_BASIC_SRC
      && !basic_gated[`EV_FF] |=> !st_reg.latched[`EV_FF])
      else $error("basic source read left the latch set");
   // Functions routed to neither pin never latch.
   unrouted_a: assert property (st_reg.p1_func == 8'h00
      && st_reg.p2_func == 8'h00 |=> st_reg.latched == 6'h00)
      else $error("unrouted function latched");
   // Unrouting free-fall from both pins drops its latch at once.
   unroute_drop_a: assert property (!st_reg.p1_func[`FN_FF]
      && !st_reg.p2_func[`FN_FF] |=> !st_reg.latched[`EV_FF])
      else $error("free-fall latch kept after unrouting");
   // Unlatched free-fall follows its condition.
   ff_follow_a: assert property (!st_reg.knock_cfg && !basic_cond_in[`EV_FF]
      |-> !summary[`EV_FF])
      else $error("unlatched free-fall stayed set");
   // High-g status needs the high-g sensor running.
   hg_gate_a: assert property (!hg_active_in |-> !summary[`SUM_HG])
      else $error("high-g event while sensor inactive");
   // Sensor-hub done routed to pin 1 asserts it.
   hub_route_a: assert property (high_live_s
      ##0 (st_reg.p1_func[`FN_LAST] && hub_done_in) |=> event_pin_one_out)
      else $error("routed hub done did not assert pin one");
   // Queue full routed to pin 1 asserts it.
   queue_route_a: assert property (high_live_s
      ##0 (st_reg.p1_data[`RT_FULL] && queue_full_in) |=> event_pin_one_out)
      else $error("routed queue full did not assert pin one");
   // Timestamp overflow routed to pin 2 asserts it unless busy routing owns the pin.
   stamp_route_a: assert property (high_live_s
      ##0 (st_reg.p2_func[`FN_LAST] && time_overflow_in && !st_reg.p2_data[`RT_P2_BUSY])
      |=> event_pin_two_out)
      else $error("routed timestamp overflow did not assert pin two");
   // Temperature ready routed to pin 2 asserts it unless busy routing owns the pin.
   temp_route_a: assert property (high_live_s
      ##0 (st_reg.ctrl_four[`C4_TEMP] && temp_ready_in && !st_reg.p2_data[`RT_P2_BUSY])
      |=> event_pin_two_out)
      else $error("routed temperature ready did not assert pin two");
   // A held write pair is answered on the next edge.
   write_resp_a: assert property (write_pair_s
      |=> s_axi_bvalid_out ##0 !s_axi_awready_out)
      else $error("write response missing");
   // A taken read address is answered on the next edge.
   read_resp_a: assert property (ar_hs
      |=> s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read response missing");

endmodule

// File: dv/host_pin_model.sv
// Host side model that resolves the two interrupt wires the processor watches.
`timescale 1ns/1ps

module host_pin_model (
   // Pin drivers from the device.
   input wire logic pin_one_in,
   input wire logic pin_one_oe_n_in,
   input wire logic pin_two_in,
   input wire logic pin_two_oe_n_in,
   // Board resistor level on both wires.
   input wire logic pull_high_in,
   // Levels as the processor sees them.
   output logic wire_one_out,
   output logic wire_two_out
);
   // A released pin shows the resistor level, never the last driven value.
   assign wire_one_out = pin_one_oe_n_in ? pull_high_in : pin_one_in;
   assign wire_two_out = pin_two_oe_n_in ? pull_high_in : pin_two_in;
endmodule

// File: dv/test_imu_interrupt_pin_router.sv
// Self-checking bench for the interrupt pin router.
`timescale 1ns/1ps
`include "pin_router_consts.svh"

module test_imu_interrupt_pin_router
   import pin_router_pkg::*;
;
   logic clock_in, reset_n_in, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, sv;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, md;
   logic hg_wu, hg_sh, hg_act, temp, emb_run, i3c, pull_high;
   logic p1, p1_oe_n, p2, p2_oe_n, w1, w2;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;

   // The bench vector sv feeds the data group (md[0] low) or the function group (md[0] high).
   imu_interrupt_pin_router dut_u (
      .clock_in(clock_in), .reset_n_in(reset_n_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .basic_cond_in(md[0] ? {sv[7], sv[2], sv[3], sv[6], sv[5], sv[4]} : 6'h00),
      .hg_wakeup_in(hg_wu), .hg_shock_in(hg_sh), .hg_active_in(hg_act),
      .queue_batch_in(!md[0] && sv[6]), .queue_full_in(!md[0] && sv[5]),
      .queue_overrun_in(!md[0] && sv[4]), .queue_threshold_in(!md[0] && sv[3]),
      .gyro_ready_in(!md[0] && sv[1]), .accel_ready_in(!md[0] && sv[0]),
      .temp_ready_in(temp), .embedded_event_in(md[0] && sv[1]),
      .embedded_running_in(emb_run), .hub_done_in(md == 2'b01 && sv[0]),
      .time_overflow_in(md == 2'b11 && sv[0]), .i3c_mode_in(i3c),
      .event_pin_one_out(p1), .event_pin_one_oe_n_out(p1_oe_n),
      .event_pin_two_out(p2), .event_pin_two_oe_n_out(p2_oe_n)
   );

   // Processor side of the pins.
   host_pin_model host_u (
      .pin_one_in(p1), .pin_one_oe_n_in(p1_oe_n), .pin_two_in(p2), .pin_two_oe_n_in(p2_oe_n),
      .pull_high_in(pull_high), .wire_one_out(w1), .wire_two_out(w2)
   );

   // Free-running clock at 125 MHz.
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end

   task automatic finish_test();
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One register write; address and data are released as each is taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ad, wd;
      logic [1:0] r;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clock_in);
      awaddr <= a;
      wdata <= {24'h000000, d};
      {awvalid, wvalid, bready} <= 3'b111;
      while (!(ad && wd)) begin
         @(negedge clock_in);
         ad = ad || awready;
         wd = wd || wready;
         @(posedge clock_in);
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
      end
      do @(negedge clock_in); while (!bvalid);
      r = bresp;
      @(posedge clock_in);
      bready <= 1'b0;
      chk({30'h0, r}, {30'h0, er});
   endtask

   // One register read compared with the expected word and response.
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clock_in);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do @(negedge clock_in); while (!arready);
      @(posedge clock_in);
      arvalid <= 1'b0;
      do @(negedge clock_in); while (!rvalid);
      d = rdata;
      r = rresp;
      @(posedge clock_in);
      rready <= 1'b0;
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // Applies a source vector and compares both wires once the pins have settled.
   task automatic ps(input logic [7:0] v, input logic e1, input logic e2);
      @(posedge clock_in);
      sv <= v;
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      chk({30'h0, w1, w2}, {30'h0, e1, e2});
   endtask

   // Hang guard well above the expected run length.
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   // Main sequence.
   initial begin
      {reset_n_in, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, sv, wdata, md} = 58'h0;
      wstrb = 4'hF;
      {hg_wu, hg_sh, hg_act, temp, emb_run, i3c, pull_high} = 7'h00;
      repeat (10) @(posedge clock_in);
      reset_n_in <= 1'b1;
      for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
      ps(8'h00, 1'b0, 1'b0);
      chk({30'h0, p1_oe_n, p2_oe_n}, 32'h0);
      rd(8'h30, 32'h0, RESP_SLVERR);
      wr(8'h30, 8'hFF, RESP_SLVERR);
      wstrb <= 4'hE;
      wr(`ADDR_P1_DATA, 8'hFF, RESP_OKAY);
      wstrb <= 4'hF;
      rd(`ADDR_P1_DATA, 32'h0, RESP_OKAY);
      wr(`ADDR_P1_DATA, 8'hFF, RESP_OKAY);
      rd(`ADDR_P1_DATA, 32'h7B, RESP_OKAY);
      wr(`ADDR_P2_DATA, 8'h7F, RESP_OKAY);
      rd(`ADDR_P2_DATA, 32'h7B, RESP_OKAY);
      wr(`ADDR_P1_DATA, 8'h00, RESP_OKAY);
      wr(`ADDR_P2_DATA, 8'h00, RESP_OKAY);
      // Basic functions on, with the high-g detector left off.
      wr(`ADDR_FUNC_EN, 8'h01, RESP_OKAY);
      // Each routing bit alone except pin 2 busy, against all other sources of its group.
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 8; b++) begin
            if (m[0] || (b != 2 && b != 7)) begin
               md <= m[1:0];
               wr(8'(4 * m), 8'(1 << b), RESP_OKAY);
               ps(8'(1 << b), !m[1], m[1]);
               ps(~8'(1 << b), 1'b0, 1'b0);
               wr(8'(4 * m), 8'h00, RESP_OKAY);
            end
         end
      end
      md <= 2'b00;
      wr(`ADDR_P1_DATA, 8'h03, RESP_OKAY);
      ps(8'h02, 1'b1, 1'b0);
      // Active low, open drain, wires pulled high.
      pull_high <= 1'b1;
      wr(`ADDR_IF_CFG, 8'h03, RESP_OKAY);
      ps(8'h00, 1'b1, 1'b1);
      chk({30'h0, p1_oe_n, p2_oe_n}, 32'h3);
      ps(8'h01, 1'b0, 1'b1);
      chk({30'h0, p1_oe_n, p1}, 32'h0);
      wr(`ADDR_IF_CFG, 8'h01, RESP_OKAY);
      ps(8'h00, 1'b1, 1'b1);
      chk({30'h0, p1_oe_n, p2_oe_n}, 32'h0);
      wr(`ADDR_IF_CFG, 8'h00, RESP_OKAY);
      pull_high <= 1'b0;
      i3c <= 1'b1;
      ps(8'h01, 1'b0, 1'b0);
      wr(`ADDR_CTRL_FIVE, 8'h01, RESP_OKAY);
      ps(8'h01, 1'b1, 1'b0);
      i3c <= 1'b0;
      wr(`ADDR_P1_DATA, 8'h00, RESP_OKAY);
      // Basic enable off blocks free-fall.
      md <= 2'b01;
      wr(`ADDR_FUNC_EN, 8'h00, RESP_OKAY);
      wr(`ADDR_P1_FUNC, 8'h10, RESP_OKAY);
      ps(8'h10, 1'b0, 1'b0);
      wr(`ADDR_FUNC_EN, 8'h01, RESP_OKAY);
      wr(`ADDR_KNOCK_CFG0, 8'h01, RESP_OKAY);
      ps(8'h00, 1'b1, 1'b0);
      rd(`ADDR_SUMMARY, 32'h1, RESP_OKAY);
      ps(8'h00, 1'b0, 1'b0);
      ps(8'h20, 1'b0, 1'b0);
      ps(8'h00, 1'b0, 1'b0);
      rd(`ADDR_SUMMARY, 32'h0, RESP_OKAY);
      wr(`ADDR_FUNC_EN, 8'h03, RESP_OKAY);
      ps(8'h10, 1'b1, 1'b0);
      rd(`ADDR_SUMMARY, 32'h1, RESP_OKAY);
      ps(8'h00, 1'b1, 1'b0);
      rd(`ADDR_BASIC_SRC, 32'h1, RESP_OKAY);
      ps(8'h00, 1'b0, 1'b0);
      ps(8'h10, 1'b1, 1'b0);
      ps(8'h00, 1'b1, 1'b0);
      wr(`ADDR_P1_FUNC, 8'h00, RESP_OKAY);
      ps(8'h00, 1'b0, 1'b0);
      wr(`ADDR_KNOCK_CFG0, 8'h00, RESP_OKAY);
      // Summary gathers high-g, embedded and hub status.
      wr(`ADDR_FUNC_EN, 8'h05, RESP_OKAY);
      {hg_act, hg_sh} <= 2'b11;
      ps(8'h03, 1'b0, 1'b0);
      rd(`ADDR_SUMMARY, 32'h1C0, RESP_OKAY);
      {hg_sh, hg_wu} <= 2'h1;
      rd(`ADDR_SUMMARY, 32'h1C0, RESP_OKAY);
      hg_act <= 1'b0;
      rd(`ADDR_SUMMARY, 32'h180, RESP_OKAY);
      hg_act <= 1'b1;
      wr(`ADDR_FUNC_EN, 8'h01, RESP_OKAY);
      rd(`ADDR_SUMMARY, 32'h180, RESP_OKAY);
      hg_wu <= 1'b0;
      // Busy indication alone on pin 2, nothing else routed there.
      md <= 2'b00;
      wr(`ADDR_P2_DATA, 8'h80, RESP_OKAY);
      ps(8'h00, 1'b0, 1'b1);
      emb_run <= 1'b1;
      ps(8'h00, 1'b0, 1'b0);
      emb_run <= 1'b0;
      wr(`ADDR_P2_DATA, 8'h00, RESP_OKAY);
      temp <= 1'b1;
      ps(8'h00, 1'b0, 1'b0);
      wr(`ADDR_CTRL_FOUR, 8'h01, RESP_OKAY);
      ps(8'h00, 1'b0, 1'b1);
      wr(`ADDR_CTRL_FOUR, 8'h03, RESP_OKAY);
      ps(8'h00, 1'b1, 1'b1);
      temp <= 1'b0;
      md <= 2'b11;
      wr(`ADDR_P2_FUNC, 8'h01, RESP_OKAY);
      ps(8'h01, 1'b1, 1'b1);
      finish_test();
   end
endmodule
